// File: tpa_cpu_model.sv
`timescale 1ns/1ns
// Core model: one data-memory move per strobe pulse
module tpa_cpu_model (
   input wire logic clk_sys,
   output logic [3:0] addr,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   // Idle bus at time zero
   initial
   begin
      addr = 4'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wdata = 8'h00;
   end
   // Single write; released data goes to its inverse
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      wdata <= ~d;
   endtask
   // Single read; data settles after the taking edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   // Pair write, low byte first
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr(lo, v[7:0]);
      wr(lo + 4'h1, v[15:8]);
   endtask
   // Pair read, high byte first
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo + 4'h1, v[15:8]);
      rd(lo, v[7:0]);
   endtask
endmodule

// File: tpa_params.svh
`ifndef TPA_PARAMS_SVH
`define TPA_PARAMS_SVH
////////////////////////////////////////////////////////////////////////////////
// Register offsets on the data-memory port
`define TPA_A_STD_C0 4'h0
`define TPA_A_STD_C1 4'h1
`define TPA_A_STD_DL 4'h2
`define TPA_A_STD_DH 4'h3
`define TPA_A_STD_AL 4'h4
`define TPA_A_STD_AH 4'h5
`define TPA_A_STD_RP 4'h6
`define TPA_A_PER_C0 4'h7
`define TPA_A_PER_C1 4'h8
`define TPA_A_PER_DL 4'h9
`define TPA_A_PER_DH 4'hA
`define TPA_A_PER_AL 4'hB
`define TPA_A_PER_AH 4'hC
`define TPA_A_PER_RPL 4'hD
`define TPA_A_PER_RPH 4'hE
`define TPA_A_PINF 4'hF
////////////////////////////////////////////////////////////////////////////////
// Reset values and masks
`define TPA_PINF_RESET 8'hC0
`define TPA_C0_MASK 8'hF8
`define TPA_REG_RESET 8'h00
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TPA_C0_PAUSE 7
`define TPA_C0_CKS_HI 6
`define TPA_C0_CKS_LO 4
`define TPA_C0_ON 3
`define TPA_C1_MODE_HI 7
`define TPA_C1_MODE_LO 6
`define TPA_C1_IO_HI 5
`define TPA_C1_IO_LO 4
`define TPA_C1_OC 3
`define TPA_C1_POL 2
`define TPA_C1_CCLR 0
`define TPA_PF_HINV 7
`define TPA_PF_LINV 6
`define TPA_PF_DSEL_HI 5
`define TPA_PF_DSEL_LO 4
`define TPA_PF_BOTH 2'h3
////////////////////////////////////////////////////////////////////////////////
// Prescaler terminal counts
`define TPA_SYS_DIV4_END 2'h3
`define TPA_FH_DIV16_END 4'hF
`define TPA_FH_DIV64_END 6'h3F
`endif

// File: tpa_pkg.sv
package tpa_pkg;
   // Operating mode field
   typedef enum logic [1:0] {tpa_mode_cmp, tpa_mode_cap, tpa_mode_pwm, tpa_mode_tmr} tpa_mode_t;
   // Compare match output action
   typedef enum logic [1:0] {tpa_io_hold, tpa_io_low, tpa_io_high, tpa_io_toggle} tpa_io_t;
   // Counter clock source
   typedef enum logic [2:0] {tpa_ck_sys4, tpa_ck_sys, tpa_ck_fh16, tpa_ck_fh64,
      tpa_ck_tbc, tpa_ck_tbc2, tpa_ck_ext_rise, tpa_ck_ext_fall} tpa_clk_sel_t;
endpackage

// File: tpa_timer.sv
`timescale 1ns/1ns
module tpa_timer #(
   parameter int CNT_W = 16,
   parameter int CMP_P_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic on,
   input wire logic pause,
   input wire logic cclr,
   input wire tpa_pkg::tpa_mode_t mode,
   input wire tpa_pkg::tpa_io_t io,
   input wire logic oc,
   input wire logic pol,
   input wire logic [CNT_W-1:0] compare_a_value,
   input wire logic [CMP_P_W-1:0] compare_p_value,
   output logic [CNT_W-1:0] count,
   output logic match_a,
   output logic match_p,
   output logic pin_level
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt; // Count-up counter
   logic out_r, out_nxt; // Compare output level
   logic on_r, on_nxt; // Previous on bit
   logic step; // Counter advances now
   logic clr_hit; // Selected clear comparator hit
   logic start; // On bit rising

   assign step = tick && on && !pause;
   // Comparator A on all bits, P on the top bits
   assign match_a = step && (cnt_r == compare_a_value);
   assign match_p = step && (cnt_r[CNT_W-1 -: CMP_P_W] == compare_p_value);
   assign clr_hit = cclr ? match_a : match_p;
   assign start = on && !on_r;

   ////////////////////////////////////////////////////////////////////////////
   // Next counter and output level
   always_comb
   begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      on_nxt = on;
      if (start)
      begin
         // Restart clears count; compare mode also reloads initial level
         cnt_nxt = '0;
         if (mode == tpa_pkg::tpa_mode_cmp)
            out_nxt = oc;
      end
      else if (step)
      begin
         // Clear on match, else count up and wrap
         if (clr_hit)
            cnt_nxt = '0;
         else
            cnt_nxt = cnt_r + 1'b1;
         if (match_a && mode == tpa_pkg::tpa_mode_cmp)
         begin
            unique case (io)
               tpa_pkg::tpa_io_hold: out_nxt = out_r;
               tpa_pkg::tpa_io_low: out_nxt = 1'b0;
               tpa_pkg::tpa_io_high: out_nxt = 1'b1;
               tpa_pkg::tpa_io_toggle: out_nxt = ~out_r;
            endcase
         end
      end
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         out_r <= 1'b0;
         on_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         out_r <= out_nxt;
         on_r <= on_nxt;
      end
   end

   assign count = cnt_r;
   // Polarity applies except in timer mode
   assign pin_level = (mode == tpa_pkg::tpa_mode_tmr) ? 1'b0 : (out_r ^ pol);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_restart;
      !on ##1 on;
   endsequence

   clear_on_match_a: assert property (step && !start && clr_hit |=> cnt_r == '0)
      else $error("counter not cleared on match");
   count_step_a: assert property (step && !start && !clr_hit |=>
      cnt_r == CNT_W'($past(cnt_r) + 1'b1))
      else $error("counter did not advance by one");
   cmp_toggle_a: assert property (match_a && !start && mode == tpa_pkg::tpa_mode_cmp &&
      io == tpa_pkg::tpa_io_toggle |=> out_r != $past(out_r))
      else $error("compare output did not toggle");
   restart_clear_a: assert property (s_restart |=> cnt_r == '0 &&
      (mode != tpa_pkg::tpa_mode_cmp || out_r == $past(oc)))
      else $error("restart did not reset counter");
endmodule

// File: tpa_top.sv
`timescale 1ns/1ns
`include "tpa_params.svh"
// Contract
// - Standard 16-bit timer and periodic 10-bit timer.
// - Compare match raises event, may clear, drive.
// - Separate events from comparator A and P.
// - Clock select picks system, high, base, external.
// - External clock counts on chosen edge.
// - Compare output mode sets, clears or toggles.
// - Pin enable bit routes pin to timer.
// - Four output enable bits, reset to zero.
// - Bit 7 inverts high side drive, resets one.
// - Bit 6 inverts low side drive, resets one.
// - Bits 5:4 route low and high drives.
// - Dead time enabled only when select is 11.
// - High byte direct, low byte via buffer.
// - Low write buffers; high write commits both.
// - High read latches low into buffer.
// - Periodic period pair uses the same buffering.
// - Second output pin forms complementary pair.
module tpa_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic fh_tick,
   input wire logic tbc_tick,
   input wire logic [1:0] timer_clock_input,
   input wire logic [1:0] pair_invert,
   input wire logic [3:0] gpio_out,
   input wire logic [3:0] gpio_oe_n,
   output logic [3:0] timer_output_pin,
   output logic [3:0] timer_output_pin_oe_n,
   input wire logic high_side_drive,
   input wire logic low_side_drive,
   input wire logic gpio_b5_out,
   input wire logic gpio_b5_oe_n,
   input wire logic gpio_b4_out,
   input wire logic gpio_b4_oe_n,
   output logic port_b_line5,
   output logic port_b_line5_oe_n,
   output logic port_b_line4,
   output logic port_b_line4_oe_n,
   output logic dead_time_enable,
   output logic [1:0] match_a,
   output logic [1:0] match_p
);
   ////////////////////////////////////////////////////////////////////////////
   // Register file state
   logic [7:0] c0_r [2]; // Clock and on control, per timer
   logic [7:0] c0_nxt [2];
   logic [7:0] c1_r [2]; // Mode and output control, per timer
   logic [7:0] c1_nxt [2];
   logic [7:0] hold_r [2]; // Low byte holding buffer, per timer
   logic [7:0] hold_nxt [2];
   logic [15:0] std_compare_a_value_r, std_compare_a_value_nxt; // Standard compare A
   logic [7:0] std_compare_p_value_r, std_compare_p_value_nxt; // Standard compare P
   logic [9:0] per_compare_a_value_r, per_compare_a_value_nxt; // Periodic compare A
   logic [9:0] per_compare_p_value_r, per_compare_p_value_nxt; // Periodic period
   logic [7:0] pinf_r, pinf_nxt; // Pin function select
   logic [7:0] rdata_r, rdata_nxt; // Read data
   logic [15:0] std_cnt; // Standard counter value
   logic [9:0] per_cnt; // Periodic counter value

   ////////////////////////////////////////////////////////////////////////////
   // Next register values: reads first, writes override
   always_comb
   begin
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      hold_nxt = hold_r;
      std_compare_a_value_nxt = std_compare_a_value_r;
      std_compare_p_value_nxt = std_compare_p_value_r;
      per_compare_a_value_nxt = per_compare_a_value_r;
      per_compare_p_value_nxt = per_compare_p_value_r;
      pinf_nxt = pinf_r;
      rdata_nxt = rdata_r;
      if (rd_en)
      begin
         unique case (addr)
            `TPA_A_STD_C0: rdata_nxt = c0_r[0];
            `TPA_A_STD_C1: rdata_nxt = c1_r[0];
            // Low bytes come from the buffer
            `TPA_A_STD_DL, `TPA_A_STD_AL: rdata_nxt = hold_r[0];
            `TPA_A_PER_DL, `TPA_A_PER_AL, `TPA_A_PER_RPL: rdata_nxt = hold_r[1];
            `TPA_A_STD_DH:
            begin
               rdata_nxt = std_cnt[15:8];
               hold_nxt[0] = std_cnt[7:0];
            end
            `TPA_A_STD_AH:
            begin
               rdata_nxt = std_compare_a_value_r[15:8];
               hold_nxt[0] = std_compare_a_value_r[7:0];
            end
            `TPA_A_STD_RP: rdata_nxt = std_compare_p_value_r;
            `TPA_A_PER_C0: rdata_nxt = c0_r[1];
            `TPA_A_PER_C1: rdata_nxt = c1_r[1];
            `TPA_A_PER_DH:
            begin
               rdata_nxt = {6'h00, per_cnt[9:8]};
               hold_nxt[1] = per_cnt[7:0];
            end
            `TPA_A_PER_AH:
            begin
               rdata_nxt = {6'h00, per_compare_a_value_r[9:8]};
               hold_nxt[1] = per_compare_a_value_r[7:0];
            end
            `TPA_A_PER_RPH:
            begin
               rdata_nxt = {6'h00, per_compare_p_value_r[9:8]};
               hold_nxt[1] = per_compare_p_value_r[7:0];
            end
            `TPA_A_PINF: rdata_nxt = pinf_r;
         endcase
      end
      if (wr_en)
      begin
         unique case (addr)
            `TPA_A_STD_C0: c0_nxt[0] = wdata & `TPA_C0_MASK;
            `TPA_A_STD_C1: c1_nxt[0] = wdata;
            // Counter bytes are read only
            `TPA_A_STD_DL, `TPA_A_STD_DH, `TPA_A_PER_DL, `TPA_A_PER_DH: ;
            // Low byte writes touch the buffer only
            `TPA_A_STD_AL: hold_nxt[0] = wdata;
            `TPA_A_PER_AL, `TPA_A_PER_RPL: hold_nxt[1] = wdata;
            // High byte write commits the buffered low byte
            `TPA_A_STD_AH: std_compare_a_value_nxt = {wdata, hold_r[0]};
            `TPA_A_STD_RP: std_compare_p_value_nxt = wdata;
            `TPA_A_PER_C0: c0_nxt[1] = wdata & `TPA_C0_MASK;
            `TPA_A_PER_C1: c1_nxt[1] = wdata;
            `TPA_A_PER_AH: per_compare_a_value_nxt = {wdata[1:0], hold_r[1]};
            `TPA_A_PER_RPH: per_compare_p_value_nxt = {wdata[1:0], hold_r[1]};
            `TPA_A_PINF: pinf_nxt = wdata;
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c0_r[0] <= `TPA_REG_RESET;
         c0_r[1] <= `TPA_REG_RESET;
         c1_r[0] <= `TPA_REG_RESET;
         c1_r[1] <= `TPA_REG_RESET;
         hold_r[0] <= `TPA_REG_RESET;
         hold_r[1] <= `TPA_REG_RESET;
         std_compare_a_value_r <= 16'h0000;
         std_compare_p_value_r <= `TPA_REG_RESET;
         per_compare_a_value_r <= 10'h000;
         per_compare_p_value_r <= 10'h000;
         pinf_r <= `TPA_PINF_RESET;
         rdata_r <= `TPA_REG_RESET;
      end
      else
      begin
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         hold_r <= hold_nxt;
         std_compare_a_value_r <= std_compare_a_value_nxt;
         std_compare_p_value_r <= std_compare_p_value_nxt;
         per_compare_a_value_r <= per_compare_a_value_nxt;
         per_compare_p_value_r <= per_compare_p_value_nxt;
         pinf_r <= pinf_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Prescalers and external clock synchronisers
   logic [1:0] pre4_r, pre4_nxt; // System clock divide by four
   logic [5:0] fh_r, fh_nxt; // High clock divider
   logic [1:0] ext_s1_r, ext_s1_nxt; // Sync first stage
   logic [1:0] ext_s2_r, ext_s2_nxt; // Sync second stage
   logic [1:0] ext_s3_r, ext_s3_nxt; // Edge detect history
   logic t_sys4, t_fh16, t_fh64; // Divided ticks
   logic [1:0] ext_rise, ext_fall; // Clean edges
   logic std_tick, per_tick; // Selected counter ticks

   // Divider and synchroniser next values
   always_comb
   begin
      pre4_nxt = pre4_r + 1'b1;
      fh_nxt = fh_r;
      if (fh_tick)
         fh_nxt = fh_r + 1'b1;
      ext_s1_nxt = timer_clock_input;
      ext_s2_nxt = ext_s1_r;
      ext_s3_nxt = ext_s2_r;
   end

   // Divider and synchroniser flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre4_r <= 2'h0;
         fh_r <= 6'h00;
         ext_s1_r <= 2'h0;
         ext_s2_r <= 2'h0;
         ext_s3_r <= 2'h0;
      end
      else
      begin
         pre4_r <= pre4_nxt;
         fh_r <= fh_nxt;
         ext_s1_r <= ext_s1_nxt;
         ext_s2_r <= ext_s2_nxt;
         ext_s3_r <= ext_s3_nxt;
      end
   end

   assign t_sys4 = (pre4_r == `TPA_SYS_DIV4_END);
   assign t_fh16 = fh_tick && (fh_r[3:0] == `TPA_FH_DIV16_END);
   assign t_fh64 = fh_tick && (fh_r == `TPA_FH_DIV64_END);
   // Edges from the second and third stages only
   assign ext_rise = ext_s2_r & ~ext_s3_r;
   assign ext_fall = ~ext_s2_r & ext_s3_r;

   // Pick the counter tick from the clock select field
   function automatic logic tick_of(input tpa_pkg::tpa_clk_sel_t sel, input logic rise,
      input logic fall);
      logic t;
      t = 1'b0;
      unique case (sel)
         tpa_pkg::tpa_ck_sys4: t = t_sys4;
         tpa_pkg::tpa_ck_sys: t = 1'b1;
         tpa_pkg::tpa_ck_fh16: t = t_fh16;
         tpa_pkg::tpa_ck_fh64: t = t_fh64;
         tpa_pkg::tpa_ck_tbc, tpa_pkg::tpa_ck_tbc2: t = tbc_tick;
         tpa_pkg::tpa_ck_ext_rise: t = rise;
         tpa_pkg::tpa_ck_ext_fall: t = fall;
      endcase
      return t;
   endfunction

   // Tick pick in a process, so the sources read inside the function are watched
   always_comb
   begin
      std_tick = tick_of(tpa_pkg::tpa_clk_sel_t'(c0_r[0][`TPA_C0_CKS_HI:`TPA_C0_CKS_LO]),
         ext_rise[0], ext_fall[0]);
      per_tick = tick_of(tpa_pkg::tpa_clk_sel_t'(c0_r[1][`TPA_C0_CKS_HI:`TPA_C0_CKS_LO]),
         ext_rise[1], ext_fall[1]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer instances
   logic [1:0] tm_lvl; // Timer output levels
   logic [1:0] tm_ma, tm_mp; // Raw match pulses

   // Standard timer, full counter against A, top byte against P
   tpa_timer #(.CNT_W(16), .CMP_P_W(8)) u_std (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(std_tick),
      .on(c0_r[0][`TPA_C0_ON]),
      .pause(c0_r[0][`TPA_C0_PAUSE]),
      .cclr(c1_r[0][`TPA_C1_CCLR]),
      .mode(tpa_pkg::tpa_mode_t'(c1_r[0][`TPA_C1_MODE_HI:`TPA_C1_MODE_LO])),
      .io(tpa_pkg::tpa_io_t'(c1_r[0][`TPA_C1_IO_HI:`TPA_C1_IO_LO])),
      .oc(c1_r[0][`TPA_C1_OC]),
      .pol(c1_r[0][`TPA_C1_POL]),
      .compare_a_value(std_compare_a_value_r),
      .compare_p_value(std_compare_p_value_r),
      .count(std_cnt),
      .match_a(tm_ma[0]),
      .match_p(tm_mp[0]),
      .pin_level(tm_lvl[0])
   );

   // Periodic timer, full 10-bit compare on both
   tpa_timer #(.CNT_W(10), .CMP_P_W(10)) u_per (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tick(per_tick),
      .on(c0_r[1][`TPA_C0_ON]),
      .pause(c0_r[1][`TPA_C0_PAUSE]),
      .cclr(c1_r[1][`TPA_C1_CCLR]),
      .mode(tpa_pkg::tpa_mode_t'(c1_r[1][`TPA_C1_MODE_HI:`TPA_C1_MODE_LO])),
      .io(tpa_pkg::tpa_io_t'(c1_r[1][`TPA_C1_IO_HI:`TPA_C1_IO_LO])),
      .oc(c1_r[1][`TPA_C1_OC]),
      .pol(c1_r[1][`TPA_C1_POL]),
      .compare_a_value(per_compare_a_value_r),
      .compare_p_value(per_compare_p_value_r),
      .count(per_cnt),
      .match_a(tm_ma[1]),
      .match_p(tm_mp[1]),
      .pin_level(tm_lvl[1])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin multiplexing
   logic [3:0] tp_lvl; // Timer levels per output pin
   logic [3:0] pin_r, pin_nxt; // Output pin data
   logic [3:0] pin_oe_n_r, pin_oe_n_nxt; // Output pin enables
   logic b5_r, b5_nxt, b5_oe_n_r, b5_oe_n_nxt; // Low side line
   logic b4_r, b4_nxt, b4_oe_n_r, b4_oe_n_nxt; // High side line
   logic dt_r, dt_nxt; // Dead time enable
   logic [1:0] ma_r, ma_nxt, mp_r, mp_nxt; // Registered match events
   logic [1:0] dsel; // Drive pin select

   // Second pin of each timer may be the inverse of the first
   assign tp_lvl = {tm_lvl[1] ^ pair_invert[1], tm_lvl[1],
      tm_lvl[0] ^ pair_invert[0], tm_lvl[0]};
   assign dsel = pinf_r[`TPA_PF_DSEL_HI:`TPA_PF_DSEL_LO];

   // Pin next values
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         // Enabled pin belongs to the timer, else to its other function
         pin_nxt[i] = pinf_r[i] ? tp_lvl[i] : gpio_out[i];
         pin_oe_n_nxt[i] = pinf_r[i] ? 1'b0 : gpio_oe_n[i];
      end
      b5_nxt = dsel[1] ? (low_side_drive ^ pinf_r[`TPA_PF_LINV]) : gpio_b5_out;
      b5_oe_n_nxt = dsel[1] ? 1'b0 : gpio_b5_oe_n;
      b4_nxt = dsel[0] ? (high_side_drive ^ pinf_r[`TPA_PF_HINV]) : gpio_b4_out;
      b4_oe_n_nxt = dsel[0] ? 1'b0 : gpio_b4_oe_n;
      dt_nxt = (dsel == `TPA_PF_BOTH);
      ma_nxt = tm_ma;
      mp_nxt = tm_mp;
   end

   // Pin flops
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_r <= 4'h0;
         pin_oe_n_r <= 4'hF;
         b5_r <= 1'b0;
         b5_oe_n_r <= 1'b1;
         b4_r <= 1'b0;
         b4_oe_n_r <= 1'b1;
         dt_r <= 1'b0;
         ma_r <= 2'h0;
         mp_r <= 2'h0;
      end
      else
      begin
         pin_r <= pin_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
         b5_r <= b5_nxt;
         b5_oe_n_r <= b5_oe_n_nxt;
         b4_r <= b4_nxt;
         b4_oe_n_r <= b4_oe_n_nxt;
         dt_r <= dt_nxt;
         ma_r <= ma_nxt;
         mp_r <= mp_nxt;
      end
   end

   assign timer_output_pin = pin_r;
   assign timer_output_pin_oe_n = pin_oe_n_r;
   assign port_b_line5 = b5_r;
   assign port_b_line5_oe_n = b5_oe_n_r;
   assign port_b_line4 = b4_r;
   assign port_b_line4_oe_n = b4_oe_n_r;
   assign dead_time_enable = dt_r;
   assign match_a = ma_r;
   assign match_p = mp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Low write, one idle cycle, then high write
   sequence s_compare_a_value_write;
      (wr_en && !rd_en && addr == `TPA_A_STD_AL) ##1 (!wr_en && !rd_en) ##1
         (wr_en && !rd_en && addr == `TPA_A_STD_AH);
   endsequence
   sequence s_per_write;
      (wr_en && !rd_en && addr == `TPA_A_PER_RPL) ##1 (!wr_en && !rd_en) ##1
         (wr_en && !rd_en && addr == `TPA_A_PER_RPH);
   endsequence

   pinf_hold_a: assert property (!(wr_en && addr == `TPA_A_PINF) |=> $stable(pinf_r))
      else $error("pin function register changed without write");
   high_inv_a: assert property (dsel[0] |=>
      port_b_line4 == $past(high_side_drive ^ pinf_r[`TPA_PF_HINV]))
      else $error("high side drive polarity wrong");
   low_inv_a: assert property (dsel[1] |=>
      port_b_line5 == $past(low_side_drive ^ pinf_r[`TPA_PF_LINV]))
      else $error("low side drive polarity wrong");
   gpio_route_a: assert property (dsel == 2'h0 |=> port_b_line5 == $past(gpio_b5_out) &&
      port_b_line4 == $past(gpio_b4_out) && port_b_line4_oe_n == $past(gpio_b4_oe_n))
      else $error("lines not left to general I/O");
   dead_time_a: assert property (wr_en && addr == `TPA_A_PINF ##1 1'b1 |=>
      dead_time_enable == ($past(wdata[5:4], 2) == `TPA_PF_BOTH))
      else $error("dead time enable wrong");
   pair_write_a: assert property (s_compare_a_value_write |=>
      std_compare_a_value_r == {$past(wdata), $past(wdata, 3)})
      else $error("compare A pair write wrong");
   low_only_a: assert property (wr_en && addr == `TPA_A_STD_AL |=> $stable(std_compare_a_value_r))
      else $error("low byte write changed compare A");
   high_read_a: assert property (rd_en && !wr_en && addr == `TPA_A_STD_DH |=>
      hold_r[0] == $past(std_cnt[7:0]) && rdata == $past(std_cnt[15:8]))
      else $error("counter high read did not latch low byte");
   per_pair_a: assert property (s_per_write |=>
      per_compare_p_value_r == {$past(wdata[1:0]), $past(wdata, 3)})
      else $error("period pair write wrong");
   pin_off_a: assert property (!pinf_r[0] |=> timer_output_pin[0] == $past(gpio_out[0]))
      else $error("disabled pin not left to other function");
endmodule

// File: tpa_top_tb.sv
`timescale 1ns/1ns
module tpa_top_tb;
   logic clk_sys;
   logic rst_n;
   logic [3:0] addr;
   logic wr_en;
   logic rd_en;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [19:0] rin; // Random side inputs
   logic [19:0] rq; // Side inputs seen at last edge
   logic [3:0] pin, pin_oe_n;
   logic b5, b5_oe_n, b4, b4_oe_n, dte;
   logic [1:0] ma, mp;
   int errors, n_compared, cyc;
   ////////////////////////////////////////////////////////////////////////////
   tpa_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .fh_tick(rin[0]), .tbc_tick(rin[1]),
      .timer_clock_input(rin[3:2]), .pair_invert(rin[5:4]), .gpio_out(rin[9:6]),
      .gpio_oe_n(rin[13:10]), .timer_output_pin(pin), .timer_output_pin_oe_n(pin_oe_n),
      .high_side_drive(rin[14]), .low_side_drive(rin[15]), .gpio_b5_out(rin[16]),
      .gpio_b5_oe_n(rin[17]), .gpio_b4_out(rin[18]), .gpio_b4_oe_n(rin[19]),
      .port_b_line5(b5), .port_b_line5_oe_n(b5_oe_n), .port_b_line4(b4),
      .port_b_line4_oe_n(b4_oe_n), .dead_time_enable(dte), .match_a(ma), .match_p(mp));
   tpa_cpu_model cpu (.clk_sys(clk_sys), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
      .wdata(wdata), .rdata(rdata));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, random side inputs, hang guard
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      rin <= 20'($urandom);
      rq <= rin;
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         errors++;
         close_out();
      end
   end
   // Compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("Error at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin : main
      logic [7:0] v, d;
      logic [15:0] w, r;
      logic [3:0] lo [3] = '{4'h4, 4'hD, 4'hB};
      logic [15:0] msk [3] = '{16'hFFFF, 16'h03FF, 16'h03FF};
      logic found, found_p;
      rin = 20'h0_0000;
      rq = 20'h0_0000;
      cyc = 0;
      errors = 0;
      n_compared = 0;
      rst_n = 1'b0;
      void'($urandom(32'h0f93));
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Pin function reset value
      cpu.rd(4'hF, d);
      chk(d, 16'h00C0);
      chk(dte, 1'b0);
      $display("test reset done");
      // Pin routing, both corners then random
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 8'h30 : (i == 1) ? 8'h1F : 8'($urandom);
         cpu.wr(4'hF, v);
         cpu.rd(4'hF, d);
         chk(d, v);
         repeat (2) @(posedge clk_sys);
         #1;
         chk(dte, v[5:4] == 2'h3);
         chk(pin_oe_n, ~v[3:0] & rq[13:10]);
         chk(pin, (v[3:0] & {rq[5], 1'b0, rq[4], 1'b0}) | (~v[3:0] & rq[9:6]));
         chk(b4, v[4] ? rq[14] ^ v[7] : rq[18]);
         chk(b5, v[5] ? rq[15] ^ v[6] : rq[16]);
         chk({b5_oe_n, b4_oe_n}, {~v[5] & rq[17], ~v[4] & rq[19]});
      end
      $display("test pin function done");
      // Buffered pairs: std compare A, per period, per compare A
      for (int i = 0; i < 9; i++)
      begin
         w = (i < 3) ? 16'hFFFF : 16'($urandom);
         cpu.wr16(lo[i % 3], w & msk[i % 3]);
         cpu.rd16(lo[i % 3], r);
         chk(r, w & msk[i % 3]);
      end
      $display("test pairs done");
      // Compare A match clears and pulses
      cpu.wr16(4'h4, 16'h0002);
      cpu.wr(4'h1, 8'h01);
      cpu.wr(4'h0, 8'h18);
      found = 1'b0;
      found_p = 1'b0;
      repeat (20)
      begin
         @(posedge clk_sys);
         #1;
         if (ma[0] === 1'b1)
            found = 1'b1;
         if (mp[0] === 1'b1)
            found_p = 1'b1;
      end
      chk(found, 1'b1);
      chk(found_p, 1'b1);
      cpu.wr(4'h0, 8'h10);
      cpu.rd16(4'h2, r);
      chk(r <= 16'h0002, 1'b1);
      $display("test match done");
      close_out();
   end
endmodule
